// File: src/pld_pkg.sv
// Summary of operation
// [R1] Chip enable low powers everything down.
// [R2] Enable high, bits clear: both sections up.
// [R3] Section bit set powers that section down.
// [R4] Auto power-up on RF divider write.
// [R5] Lock after five good reference cycles.
// [R6] Locked: drop on wider unlock threshold.
// [R7] RF thresholds 10 ns and 20 ns.
// [R8] IF thresholds 15 ns and 30 ns.
// [R9] Powered-down section shows lock low.
// [R10] Host sets quarter rate above 20 MHz.
// [R11] Quarter rate divides lock evaluation by four.
// [R12] Combined lock low if either unlocked.
// [R13] RF current sixteen steps, IF fixed.
// [R14] RF higher current while acquiring lock.
// [R15] Charge pump drives only during error.
// [R16] Host keeps RF comparison within limits.
// [R17] Four-bit select drives test pin.
// [R18] Thresholds counted in sampling clock cycles.
package pld_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int RF_ENTRY_NS = 10;
    localparam int RF_UNLOCK_NS = 20;
    localparam int IF_ENTRY_NS = 15;
    localparam int IF_UNLOCK_NS = 30;
    localparam int RF_ENTRY_CYC = (RF_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RF_UNLOCK_CYC = (RF_UNLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IF_ENTRY_CYC = (IF_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IF_UNLOCK_CYC = (IF_UNLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] LOCK_GOOD_CYCLES = 3'h5;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RF_CP = 8'h04;
    localparam logic [7:0] ADDR_RF_N = 8'h08;
    localparam logic [7:0] ADDR_THRESH = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // CTRL fields.
    localparam int CTRL_RF_SECTION_POWER_DOWN = 0;
    localparam int CTRL_IF_SECTION_POWER_DOWN = 1;
    localparam int CTRL_AUTO_POWER_UP_ON_DIVIDER_WRITE = 2;
    localparam int CTRL_QUARTER = 3;
    localparam int CTRL_FASTLOCK = 4;
    localparam int CTRL_SEL_LSB = 8;

    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] RF_CP_RESET = 8'hf0;
    localparam logic [21:0] RF_N_RESET = 22'h00_0000;
    localparam logic [31:0] THRESH_RESET = {8'(IF_UNLOCK_CYC), 8'(IF_ENTRY_CYC),
                                            8'(RF_UNLOCK_CYC), 8'(RF_ENTRY_CYC)};

    // Interrupt status bits: RF gained, RF lost, IF gained, IF lost.
    localparam int IRQ_W = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SEL_LOW = 4'h0,
        SEL_HIGH = 4'h1,
        SEL_RF_LOCK = 4'h2,
        SEL_IF_LOCK = 4'h3,
        SEL_BOTH_LOCK = 4'h4,
        SEL_IF_N_HALF = 4'hd,
        SEL_RF_N_HALF = 4'hf
    } pld_sel_t;

    typedef struct packed {
        logic [7:0] entry;
        logic [7:0] unlock;
    } pld_thresh_t;

    typedef struct packed {
        logic up;
        logic down;
        logic ref_clk;
        logic feedback;
    } pld_pins_t;

endpackage : pld_pkg

// File: src/pld_top.sv
`timescale 1ns/100ps
`default_nettype none
module pld_top #(
    parameter int CNT_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_enable,
    input wire logic [1:0] i_pd_up,
    input wire logic [1:0] i_pd_down,
    input wire logic [1:0] i_ref_clk,
    input wire logic i_rf_feedback_input,
    input wire logic i_if_feedback_input,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_rf_powered,
    output logic o_if_powered,
    output logic [1:0] o_lock,
    output logic [3:0] o_rf_cp_current,
    output logic [1:0] o_cp_up_drive,
    output logic [1:0] o_cp_down_drive,
    output logic [1:0] o_cp_oe,
    output logic o_test_lock_output_pin
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pld_pkg::pld_pins_t [1:0] pins;
    pld_pkg::pld_pins_t [1:0] pins_s1_r;
    pld_pkg::pld_pins_t [1:0] pins_s2_r;
    pld_pkg::pld_pins_t [1:0] pins_s3_r;
    logic ce_s1_r;
    logic ce_s2_r;

    always_comb begin
        pins[0] = '{up: i_pd_up[0], down: i_pd_down[0], ref_clk: i_ref_clk[0],
                    feedback: i_rf_feedback_input};
        pins[1] = '{up: i_pd_up[1], down: i_pd_down[1], ref_clk: i_ref_clk[1],
                    feedback: i_if_feedback_input};
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pins_s1_r <= '0;
            pins_s2_r <= '0;
            pins_s3_r <= '0;
            ce_s1_r <= 1'b0;
            ce_s2_r <= 1'b0;
        end else begin
            pins_s1_r <= pins;
            pins_s2_r <= pins_s1_r;
            pins_s3_r <= pins_s2_r;
            ce_s1_r <= i_chip_enable;
            ce_s2_r <= ce_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [7:0] rf_cp_r;
    logic [21:0] rf_n_r;
    logic [31:0] thresh_r;
    logic [pld_pkg::IRQ_W-1:0] irq_stat_r;
    logic [pld_pkg::IRQ_W-1:0] irq_mask_r;
    logic [pld_pkg::IRQ_W-1:0] irq_event;
    logic [1:0] lock_r;
    logic [1:0] sec_pd;
    logic [1:0] sec_on;
    logic [31:0] rdata_nxt;
    logic wr_ctrl;
    logic wr_rf_n;

    assign wr_ctrl = i_wr && (i_addr == pld_pkg::ADDR_CTRL);
    assign wr_rf_n = i_wr && (i_addr == pld_pkg::ADDR_RF_N);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= pld_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= i_wdata;
            end
            // [R4] auto power-up clears
            if (wr_rf_n && ce_s2_r && (wr_ctrl ? i_wdata[pld_pkg::CTRL_AUTO_POWER_UP_ON_DIVIDER_WRITE]
                                                     : ctrl_r[pld_pkg::CTRL_AUTO_POWER_UP_ON_DIVIDER_WRITE])) begin
                ctrl_r[pld_pkg::CTRL_RF_SECTION_POWER_DOWN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rf_cp_r <= pld_pkg::RF_CP_RESET;
            rf_n_r <= pld_pkg::RF_N_RESET;
            thresh_r <= pld_pkg::THRESH_RESET;
            irq_mask_r <= '0;
        end else if (i_wr) begin
            case (i_addr)
                pld_pkg::ADDR_RF_CP: rf_cp_r <= i_wdata[7:0];
                pld_pkg::ADDR_RF_N: rf_n_r <= i_wdata[21:0];
                pld_pkg::ADDR_THRESH: thresh_r <= i_wdata;
                pld_pkg::ADDR_IRQ_MASK: irq_mask_r <= i_wdata[pld_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // A new event in the same cycle as its clear is kept.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_stat_r <= '0;
        end else if (i_wr && (i_addr == pld_pkg::ADDR_IRQ_STAT)) begin
            irq_stat_r <= (irq_stat_r & ~i_wdata[pld_pkg::IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat_r <= irq_stat_r | irq_event;
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (i_addr)
            pld_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
            pld_pkg::ADDR_RF_CP: rdata_nxt = {24'h00_0000, rf_cp_r};
            pld_pkg::ADDR_RF_N: rdata_nxt = {10'h000, rf_n_r};
            pld_pkg::ADDR_THRESH: rdata_nxt = thresh_r;
            pld_pkg::ADDR_STATUS: rdata_nxt = {27'h000_0000, ce_s2_r, sec_on, lock_r};
            pld_pkg::ADDR_IRQ_STAT: rdata_nxt = {28'h000_0000, irq_stat_r};
            pld_pkg::ADDR_IRQ_MASK: rdata_nxt = {28'h000_0000, irq_mask_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= i_rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------------
    assign sec_pd = {ctrl_r[pld_pkg::CTRL_IF_SECTION_POWER_DOWN], ctrl_r[pld_pkg::CTRL_RF_SECTION_POWER_DOWN]};

    // [R1] [R2] [R3] pin gates asynchronously
    // The pin is used raw here so power-down does not wait for a clock.
    assign o_rf_powered = i_chip_enable && !sec_pd[0];
    assign o_if_powered = i_chip_enable && !sec_pd[1];

    // Internal logic sees the synchronised enable.
    assign sec_on = {ce_s2_r && !sec_pd[1], ce_s2_r && !sec_pd[0]};

    // ------------------------------------------------------------------
    // Lock detectors, one per section (0 = RF, 1 = IF)
    // ------------------------------------------------------------------
    pld_pkg::pld_thresh_t [1:0] thr;
    logic [1:0] half_r;

    assign thr[0] = '{entry: thresh_r[7:0], unlock: thresh_r[15:8]};
    assign thr[1] = '{entry: thresh_r[23:16], unlock: thresh_r[31:24]};

    for (genvar g = 0; g < 2; g++) begin : g_sec
        logic err;
        logic ref_edge;
        logic fb_edge;
        logic eval_cyc;
        logic eval_next;
        logic [1:0] quarter_r;
        logic [CNT_W-1:0] width_r;
        logic [2:0] good_r;
        logic lock_nxt;
        logic [2:0] good_nxt;

        assign err = pins_s2_r[g].up || pins_s2_r[g].down;
        assign ref_edge = pins_s2_r[g].ref_clk && !pins_s3_r[g].ref_clk;
        assign fb_edge = pins_s2_r[g].feedback && !pins_s3_r[g].feedback;
        // [R11] one cycle in four
        assign eval_cyc = !ctrl_r[pld_pkg::CTRL_QUARTER] || (quarter_r == 2'h3);
        assign eval_next = !ctrl_r[pld_pkg::CTRL_QUARTER] || (quarter_r == 2'h2);

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                quarter_r <= 2'h0;
            end else if (ref_edge) begin
                quarter_r <= quarter_r + 2'h1;
            end
        end

        // [R18] error width in cycles
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                width_r <= '0;
            end else if (ref_edge) begin
                // A pump pulse opens on the reference edge, so its first cycle starts
                // the new count; dropping it would let a one-cycle error pass as zero.
                width_r <= CNT_W'(err && eval_next);
            end else if (err && eval_cyc && !(&width_r)) begin
                width_r <= width_r + 1'b1;
            end
        end

        always_comb begin
            lock_nxt = lock_r[g];
            good_nxt = good_r;
            if (!sec_on[g]) begin
                // [R9] powered down unlocks
                lock_nxt = 1'b0;
                good_nxt = 3'h0;
            end else if (lock_r[g]) begin
                // [R6] [R7] [R8] wide unlock limit
                if (width_r > thr[g].unlock) begin
                    lock_nxt = 1'b0;
                    good_nxt = 3'h0;
                end
            end else if (ref_edge && eval_cyc) begin
                // [R5] five good cycles
                if (width_r < thr[g].entry) begin
                    good_nxt = good_r + 3'h1;
                    lock_nxt = (good_nxt == pld_pkg::LOCK_GOOD_CYCLES);
                end else begin
                    good_nxt = 3'h0;
                end
            end
        end

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                lock_r[g] <= 1'b0;
                good_r <= 3'h0;
            end else begin
                lock_r[g] <= lock_nxt;
                good_r <= lock_nxt ? 3'h0 : good_nxt;
            end
        end

        assign irq_event[2*g] = lock_nxt && !lock_r[g];
        assign irq_event[2*g+1] = !lock_nxt && lock_r[g];

        // Divide-by-two of the feedback counter gives a 50% duty test signal.
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                half_r[g] <= 1'b0;
            end else if (fb_edge) begin
                half_r[g] <= !half_r[g];
            end
        end

        // [R15] drive only during pulse
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                o_cp_up_drive[g] <= 1'b0;
                o_cp_down_drive[g] <= 1'b0;
                o_cp_oe[g] <= 1'b0;
            end else begin
                o_cp_up_drive[g] <= sec_on[g] && pins_s2_r[g].up;
                o_cp_down_drive[g] <= sec_on[g] && pins_s2_r[g].down;
                o_cp_oe[g] <= sec_on[g] && err;
            end
        end
    end

    assign o_lock = lock_r;

    // ------------------------------------------------------------------
    // RF charge pump current
    // ------------------------------------------------------------------
    // [R13] [R14] fast until locked
    // The IF pump has no current setting at all; its magnitude is fixed.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rf_cp_current <= 4'h0;
        end else if (ctrl_r[pld_pkg::CTRL_FASTLOCK] && !lock_r[0]) begin
            o_rf_cp_current <= rf_cp_r[7:4];
        end else begin
            o_rf_cp_current <= rf_cp_r[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Test / lock output
    // ------------------------------------------------------------------
    pld_pkg::pld_sel_t sel;

    assign sel = pld_pkg::pld_sel_t'(ctrl_r[pld_pkg::CTRL_SEL_LSB +: 4]);

    // [R17] output select
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_test_lock_output_pin <= 1'b0;
        end else begin
            case (sel)
                pld_pkg::SEL_HIGH: o_test_lock_output_pin <= 1'b1;
                pld_pkg::SEL_RF_LOCK: o_test_lock_output_pin <= lock_r[0];
                pld_pkg::SEL_IF_LOCK: o_test_lock_output_pin <= lock_r[1];
                // [R12] both must be locked
                pld_pkg::SEL_BOTH_LOCK: o_test_lock_output_pin <= &lock_r;
                pld_pkg::SEL_RF_N_HALF: o_test_lock_output_pin <= half_r[0];
                pld_pkg::SEL_IF_N_HALF: o_test_lock_output_pin <= half_r[1];
                default: o_test_lock_output_pin <= 1'b0;
            endcase
        end
    end

endmodule : pld_top
`default_nettype wire

// File: tb/pld_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pld_assertions (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_enable,
    input wire logic [1:0] i_pd_up,
    input wire logic [1:0] i_pd_down,
    input wire logic [1:0] i_ref_clk,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_lock,
    input wire logic o_rf_powered,
    input wire logic o_if_powered,
    input wire logic [1:0] o_cp_up_drive,
    input wire logic [1:0] o_cp_down_drive,
    input wire logic o_test_lock_output_pin
);
    logic [11:0] ctl_r;
    logic [1:0] ref_q;
    logic [1:0][4:0] good_r;
    logic [1:0] pw;
    logic ce1_r;
    logic ce2_r;
    assign pw = {o_if_powered, o_rf_powered};
    // The auto power-up path looks at the synchronised enable, as the design does.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ce1_r <= 1'b0;
            ce2_r <= 1'b0;
        end else begin
            ce1_r <= i_chip_enable;
            ce2_r <= ce1_r;
        end
    end
    // Shadow of the control word, so power state and select are known here.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_r <= 12'h0;
        end else if (i_wr && i_addr == pld_pkg::ADDR_CTRL) begin
            ctl_r <= i_wdata[11:0];
        end else if (i_wr && i_addr == pld_pkg::ADDR_RF_N && ctl_r[2] && ce2_r) begin
            ctl_r[0] <= 1'b0;
        end
    end
    // Pin edges while unlocked; the detector sees each later, so this count never lags it.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_q <= 2'h0;
            good_r <= '0;
        end else begin
            ref_q <= i_ref_clk;
            for (int s = 0; s < 2; s++) begin
                if (o_lock[s] || !pw[s]) begin
                    good_r[s] <= 5'h0;
                end else if (i_ref_clk[s] && !ref_q[s] && good_r[s] != 5'h1f) begin
                    good_r[s] <= good_r[s] + 5'h1;
                end
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rf_pow; o_rf_powered == (i_chip_enable && !ctl_r[0]); endproperty
    a_rf_pow: assert property (p_rf_pow) else $error("rf power state wrong");
    property p_if_pow; o_if_powered == (i_chip_enable && !ctl_r[1]); endproperty
    a_if_pow: assert property (p_if_pow) else $error("if power state wrong");
    property p_ce_lock; !i_chip_enable [*4] |-> o_lock == 2'h0; endproperty
    a_ce_lock: assert property (p_ce_lock) else $error("lock kept with chip off");
    property p_rf_off; !o_rf_powered [*4] |-> !o_lock[0]; endproperty
    a_rf_off: assert property (p_rf_off) else $error("rf lock kept while off");
    property p_if_off; !o_if_powered [*4] |-> !o_lock[1]; endproperty
    a_if_off: assert property (p_if_off) else $error("if lock kept while off");
    property p_q_rf; $rose(o_lock[0]) |-> good_r[0] >= (ctl_r[3] ? 5'h11 : 5'h5); endproperty
    a_q_rf: assert property (p_q_rf) else $error("rf lock too early");
    property p_q_if; $rose(o_lock[1]) |-> good_r[1] >= (ctl_r[3] ? 5'h11 : 5'h5); endproperty
    a_q_if: assert property (p_q_if) else $error("if lock too early");
    property p_cp; (o_cp_up_drive & ~$past(i_pd_up, 3)) == 2'h0
        && (o_cp_down_drive & ~$past(i_pd_down, 3)) == 2'h0; endproperty
    a_cp: assert property (p_cp) else $error("pump drive without error");
    property p_sel_hi; $past(ctl_r[11:8]) == 4'h1 |-> o_test_lock_output_pin; endproperty
    a_sel_hi: assert property (p_sel_hi) else $error("test pin not high");
    property p_both; $past(ctl_r[11:8]) == 4'h4
        |-> o_test_lock_output_pin == &$past(o_lock); endproperty
    a_both: assert property (p_both) else $error("combined lock wrong");
    property p_rdata; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule : pld_assertions
bind pld_top pld_assertions i_chk (.i_clk, .i_rst, .i_chip_enable, .i_pd_up, .i_pd_down,
    .i_ref_clk, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_lock, .o_rf_powered,
    .o_if_powered, .o_cp_up_drive, .o_cp_down_drive, .o_test_lock_output_pin);
`default_nettype wire

// File: tb/pld_partner.sv
`timescale 1ns/100ps
`default_nettype none
module pld_partner (
    input wire logic i_clk,
    input wire logic [7:0] i_err_rf,
    input wire logic [7:0] i_err_if,
    output logic [1:0] o_ref_clk,
    output logic [1:0] o_up,
    output logic [1:0] o_down,
    output logic o_fb_rf,
    output logic o_fb_if
);
    logic [3:0] ph_r = 4'h0;
    always_ff @(posedge i_clk) begin
        ph_r <= ph_r + 4'h1;
    end
    assign o_ref_clk = {2{ph_r[3]}};
    assign o_fb_rf = ph_r[0];
    assign o_fb_if = ph_r[1];
    // The RF loop lags and pumps up, the IF loop leads and pumps down.
    assign o_up = {1'b0, ph_r[3] && ({5'h0, ph_r[2:0]} < i_err_rf)};
    assign o_down = {ph_r[3] && ({5'h0, ph_r[2:0]} < i_err_if), 1'b0};
endmodule : pld_partner
`default_nettype wire

// File: tb/pld_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pld_tb_top;
    logic clk = 1'b0;
    logic rst, ce, wr_s, rd_s, irq, rf_pw, if_pw, pin, fb_rf, fb_if, v;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, pwr;
    logic [1:0][7:0] err;
    logic [1:0] lock, ref_clk, up, down, cp_up, cp_dn, cp_oe;
    logic [3:0] cp_cur;
    int n_mismatch = 0;
    int compares = 0;
    int n_oe = 0;
    int n_up = 0;
    int n_dn = 0;
    assign pwr = {30'h0, rf_pw, if_pw};
    always #25 clk = ~clk;
    pld_partner i_far (.i_clk(clk), .i_err_rf(err[0]), .i_err_if(err[1]), .o_ref_clk(ref_clk),
        .o_up(up), .o_down(down), .o_fb_rf(fb_rf), .o_fb_if(fb_if));
    pld_top i_dut (.i_clk(clk), .i_rst(rst), .i_chip_enable(ce), .i_pd_up(up), .i_pd_down(down),
        .i_ref_clk(ref_clk), .i_rf_feedback_input(fb_rf), .i_if_feedback_input(fb_if),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_irq(irq),
        .o_rf_powered(rf_pw), .o_if_powered(if_pw), .o_lock(lock), .o_rf_cp_current(cp_cur),
        .o_cp_up_drive(cp_up), .o_cp_down_drive(cp_dn), .o_cp_oe(cp_oe),
        .o_test_lock_output_pin(pin));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("n_mismatch=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    // Ends just after an edge so that registered outputs have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd
    task automatic wait_lock(input int s, input logic lv, input int lim);
        int n;
        n = 0;
        while (lock[s] !== lv && n < lim) begin
            cyc(1);
            n++;
        end
        chk1(lock[s], lv);
        if (lock[s] !== lv) results();
    endtask : wait_lock
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        addr = 8'h0;
        wdata = 32'h0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        err = 16'h0101;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(pld_pkg::ADDR_CTRL, pld_pkg::CTRL_RESET);
        rd(pld_pkg::ADDR_RF_CP, {24'h0, pld_pkg::RF_CP_RESET});
        rd(pld_pkg::ADDR_THRESH, pld_pkg::THRESH_RESET);
        rd(8'h1c, 32'h0);
        chk(pwr, 32'h3);
        for (int k = 1; k < 3; k++) begin
            wr(pld_pkg::ADDR_CTRL, 32'(k));
            cyc(4);
            chk(pwr, 32'(k));
        end
        wr(pld_pkg::ADDR_CTRL, 32'h7);
        wr(pld_pkg::ADDR_RF_N, 32'h5);
        chk(pwr, 32'h2);
        rd(pld_pkg::ADDR_CTRL, 32'h6);
        rd(pld_pkg::ADDR_RF_N, 32'h5);
        @(posedge clk) ce <= 1'b0;
        wr(pld_pkg::ADDR_CTRL, 32'h0);
        chk(pwr, 32'h0);
        @(posedge clk) ce <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            cyc(160);
            chk1(lock[s], 1'b0);
            err[s] = 8'h0;
            wait_lock(s, 1'b1, 120);
            err[s] = 8'h1;
            cyc(160);
            chk1(lock[s], 1'b1);
            err[s] = 8'h2;
            wait_lock(s, 1'b0, 40);
        end
        wr(pld_pkg::ADDR_THRESH, 32'h0101_0403);
        wait_lock(0, 1'b1, 120);
        wr(pld_pkg::ADDR_THRESH, pld_pkg::THRESH_RESET);
        wait_lock(0, 1'b0, 40);
        rd(pld_pkg::ADDR_IRQ_STAT, 32'hf);
        wr(pld_pkg::ADDR_IRQ_MASK, 32'h2);
        chk1(irq, 1'b1);
        wr(pld_pkg::ADDR_IRQ_STAT, 32'h2);
        chk1(irq, 1'b0);
        rd(pld_pkg::ADDR_IRQ_STAT, 32'hd);
        wr(pld_pkg::ADDR_IRQ_MASK, 32'h0);
        err = 16'h0;
        wait_lock(0, 1'b1, 120);
        wait_lock(1, 1'b1, 120);
        rd(pld_pkg::ADDR_STATUS, 32'h1f);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++) begin
                wr(pld_pkg::ADDR_CTRL, 32'(k) << 8);
                cyc(1);
                chk1(pin, k == 1 || k == 2 || (p == 0 && k > 2));
            end
            err[1] = 8'h2;
            wait_lock(1, 1'b0, 40);
        end
        wr(pld_pkg::ADDR_CTRL, 32'h201);
        cyc(2);
        chk1(pin, 1'b0);
        for (int k = 0; k < 2; k++) begin
            wr(pld_pkg::ADDR_CTRL, (k == 0) ? 32'hf00 : 32'hd00);
            cyc(8);
            v = pin;
            cyc(2 + 2 * k);
            chk1(pin, !v);
        end
        err[0] = 8'h2;
        wr(pld_pkg::ADDR_RF_CP, 32'ha5);
        wr(pld_pkg::ADDR_CTRL, 32'h10);
        cyc(1);
        chk({28'h0, cp_cur}, 32'ha);
        err[0] = 8'h0;
        wait_lock(0, 1'b1, 120);
        cyc(1);
        chk({28'h0, cp_cur}, 32'h5);
        wr(pld_pkg::ADDR_RF_CP, 32'h0c);
        wr(pld_pkg::ADDR_CTRL, 32'h0);
        cyc(1);
        chk({28'h0, cp_cur}, 32'hc);
        err[0] = 8'h2;
        wait_lock(0, 1'b0, 40);
        // Both pumps now see steady two-cycle errors, so 32 cycles hold two pulses, four drive cycles.
        cyc(16);
        repeat (32) begin
            cyc(1);
            n_oe += int'(cp_oe[0]);
            n_up += int'(cp_up[0]);
            n_dn += int'(cp_dn[1]);
        end
        chk(32'(n_oe), 32'h4);
        chk(32'(n_up), 32'h4);
        chk(32'(n_dn), 32'h4);
        wr(pld_pkg::ADDR_CTRL, 32'h8);
        err[0] = 8'h0;
        cyc(192);
        chk1(lock[0], 1'b0);
        wait_lock(0, 1'b1, 240);
        @(posedge clk) ce <= 1'b0;
        cyc(4);
        chk({30'h0, lock}, 32'h0);
        results();
    end
endmodule : pld_tb_top
`default_nettype wire
